// ==== core/acl_consts.vh ====
/*
 Constants for the angle counter tooth logic: register offsets, field positions,
 reset values and mode codes. Assumes inclusion by bare name from core/.
*/
`ifndef ACL_CONSTS_VH
`define ACL_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ACL_OFF_TOOTH_PROG 12'h000
`define ACL_OFF_TICK_RATE 12'h004
`define ACL_OFF_PRESCALE 12'h008
`define ACL_OFF_STATUS 12'h00C
`define ACL_OFF_TIME_BASE 12'h010

// ----------------------------------------------------------------
// tooth program register fields
// ----------------------------------------------------------------
`define ACL_TPR_TICKS_LSB 0
`define ACL_TPR_TICKS_MSB 9
`define ACL_TPR_MISS_LSB 10
`define ACL_TPR_MISS_MSB 11
`define ACL_TPR_LAST_BIT 12
`define ACL_TPR_INSERT_BIT 13

// ----------------------------------------------------------------
// tick rate: 15-bit integer part above a 9-bit fraction
// ----------------------------------------------------------------
`define ACL_TRR_FRAC_W 9
`define ACL_TRR_W 24
`define ACL_TRR_RESET 24'h000200
`define ACL_PRESCALE_W 6
`define ACL_PRESCALE_RESET 6'h00

// ----------------------------------------------------------------
// modes
// ----------------------------------------------------------------
`define ACL_MODE_HIGH_RATE 2'h0
`define ACL_MODE_NORMAL 2'h1
`define ACL_MODE_HALT 2'h2

`endif

// ==== core/acl_tick_gen.v ====
/*
 Tick generator: adds one whole step per prescaled microcycle and emits a tick
 each time a tick rate with a nonzero integer part is covered. Assumes a rate in 15.9 fixed point.
*/
module acl_tick_gen (
	input wire clk,
	input wire rst,
	input wire restart,
	input wire [5:0] prescale,
	input wire [23:0] tick_rate,
	output reg tick
);
	reg [5:0] pre_cnt;
	reg [23:0] acc;
	wire step;
	wire [24:0] sum;

	assign step = (pre_cnt == prescale);
	assign sum = {1'b0, acc} + 25'h0000200;

	// ----------------------------------------------------------------
	// prescaler and phase accumulator
	// ----------------------------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pre_cnt <= 6'h00;
			acc <= 24'h000000;
			tick <= 1'b0;
		end else if (restart) begin
			pre_cnt <= 6'h00;
			acc <= 24'h000000;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (step) begin
				pre_cnt <= 6'h00;
				// remainder is kept, so a fractional rate spreads its ticks evenly
				if (sum >= {1'b0, tick_rate} && tick_rate[23:9] != 15'h0000) begin
					acc <= sum[23:0] - tick_rate;
					tick <= 1'b1;
				end else begin
					acc <= sum[23:0];
				end
			end else begin
				pre_cnt <= pre_cnt + 6'h01;
			end
		end
	end
endmodule

// ==== core/acl_angle_counter.v ====
/*
 Angle counter tooth logic with an APB register slave. Tracks tooth edges in
 High Rate, Normal and Halt modes. Assumes tooth_in is synchronous to clk and
 that one clk cycle is one microcycle.
*/
`include "acl_consts.vh"

module acl_angle_counter (
	input wire clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire tooth_in,
	output reg [1:0] mode,
	output reg [23:0] angle_time_base
);
	reg [9:0] ticks_per_tooth;
	reg [9:0] ticks_pending;
	reg ticks_pend_valid;
	reg [1:0] missing_tooth_count;
	reg last_tooth;
	reg insert_tooth_bit;
	reg insert_req;
	reg [31:0] buf_data;
	reg buf_valid;
	reg [23:0] tick_rate_reg;
	reg [5:0] time_base_prescaler;
	reg [9:0] tick_in_tooth;
	reg [31:0] next_prdata;
	wire tick;
	wire tooth;
	wire wr_en;
	wire rd_en;
	wire tpr_wr;
	wire mapped;
	wire early;
	wire tooth_due;
	reg tb_restart;

	// ----------------------------------------------------------------
	// apb decode, zero wait
	// ----------------------------------------------------------------
	assign pready = 1'b1;
	assign mapped = (paddr == `ACL_OFF_TOOTH_PROG) || (paddr == `ACL_OFF_TICK_RATE) ||
		(paddr == `ACL_OFF_PRESCALE) || (paddr == `ACL_OFF_STATUS) ||
		(paddr == `ACL_OFF_TIME_BASE);
	assign pslverr = psel & penable & ~mapped;
	assign wr_en = psel & penable & pwrite & mapped;
	assign rd_en = psel & ~penable & ~pwrite;
	assign tpr_wr = wr_en & (paddr == `ACL_OFF_TOOTH_PROG);

	// dummy tooth merges with the real edge, so both take the same path
	assign tooth = tooth_in | insert_req;
	assign early = (tick_in_tooth < ticks_per_tooth);
	assign tooth_due = tick & (tick_in_tooth + 10'h001 >= ticks_per_tooth);

	acl_tick_gen u_tick (
		.clk(clk),
		.rst(rst),
		.restart(tb_restart),
		.prescale(time_base_prescaler),
		.tick_rate(tick_rate_reg),
		.tick(tick)
	);

	// ----------------------------------------------------------------
	// read mux, registered in the setup cycle
	// ----------------------------------------------------------------
	always @* begin
		next_prdata = 32'h00000000;
		case (paddr)
			`ACL_OFF_TOOTH_PROG: next_prdata = {18'h00000, insert_tooth_bit, last_tooth,
				missing_tooth_count, ticks_per_tooth};
			`ACL_OFF_TICK_RATE: next_prdata = {8'h00, tick_rate_reg};
			`ACL_OFF_PRESCALE: next_prdata = {26'h0000000, time_base_prescaler};
			`ACL_OFF_STATUS: next_prdata = {28'h0000000, buf_valid, ticks_pend_valid, mode};
			`ACL_OFF_TIME_BASE: next_prdata = {8'h00, angle_time_base};
			default: next_prdata = 32'h00000000;
		endcase
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h00000000;
		end else if (rd_en) begin
			prdata <= next_prdata;
		end
	end

	// ----------------------------------------------------------------
	// tooth program, mode machine and time base, one step per cycle
	// ----------------------------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ticks_per_tooth <= 10'h000;
			ticks_pending <= 10'h000;
			ticks_pend_valid <= 1'b0;
			missing_tooth_count <= 2'h0;
			last_tooth <= 1'b0;
			insert_tooth_bit <= 1'b0;
			insert_req <= 1'b0;
			buf_data <= 32'h00000000;
			buf_valid <= 1'b0;
			tick_rate_reg <= `ACL_TRR_RESET;
			time_base_prescaler <= `ACL_PRESCALE_RESET;
			mode <= `ACL_MODE_HIGH_RATE;
			angle_time_base <= 24'h000000;
			tick_in_tooth <= 10'h000;
			tb_restart <= 1'b0;
		end else begin
			tb_restart <= 1'b0;
			insert_req <= 1'b0;
			if (wr_en && paddr == `ACL_OFF_TICK_RATE)
				tick_rate_reg <= pwdata[23:0];
			if (wr_en && paddr == `ACL_OFF_PRESCALE)
				time_base_prescaler <= pwdata[5:0];
			// second write after an insert write waits one cycle in the buffer
			if (tpr_wr && (insert_tooth_bit || insert_req)) begin
				buf_data <= pwdata;
				buf_valid <= 1'b1;
			end else if (tpr_wr || buf_valid) begin
				buf_valid <= 1'b0;
				missing_tooth_count <= tpr_wr ? pwdata[`ACL_TPR_MISS_MSB:`ACL_TPR_MISS_LSB] :
					buf_data[`ACL_TPR_MISS_MSB:`ACL_TPR_MISS_LSB];
				last_tooth <= tpr_wr ? pwdata[`ACL_TPR_LAST_BIT] : buf_data[`ACL_TPR_LAST_BIT];
				if (tpr_wr && pwdata[`ACL_TPR_INSERT_BIT]) begin
					insert_tooth_bit <= 1'b1;
					insert_req <= 1'b1;
				end
				// ticks value written in normal mode waits for the halt tooth
				if (mode == `ACL_MODE_NORMAL) begin
					ticks_pending <= tpr_wr ? pwdata[`ACL_TPR_TICKS_MSB:`ACL_TPR_TICKS_LSB] :
						buf_data[`ACL_TPR_TICKS_MSB:`ACL_TPR_TICKS_LSB];
					ticks_pend_valid <= 1'b1;
				end else begin
					ticks_per_tooth <= tpr_wr ? pwdata[`ACL_TPR_TICKS_MSB:`ACL_TPR_TICKS_LSB] :
						buf_data[`ACL_TPR_TICKS_MSB:`ACL_TPR_TICKS_LSB];
				end
			end
			if (tick && mode != `ACL_MODE_HALT) begin
				angle_time_base <= angle_time_base + 24'h000001;
				tick_in_tooth <= tick_in_tooth + 10'h001;
			end
			case (mode)
				`ACL_MODE_HIGH_RATE: begin
					if (tooth) begin
						// the dummy tooth is used up here, so later writes are not held
						insert_tooth_bit <= 1'b0;
						tick_in_tooth <= 10'h000;
						mode <= `ACL_MODE_NORMAL;
					end
				end
				`ACL_MODE_NORMAL: begin
					if (tooth && last_tooth) begin
						last_tooth <= 1'b0;
						insert_tooth_bit <= 1'b0;
						angle_time_base <= 24'h000000;
						tb_restart <= 1'b1;
						tick_in_tooth <= 10'h000;
						mode <= `ACL_MODE_HALT;
					end else if (tooth && early && missing_tooth_count != 2'h0) begin
						mode <= `ACL_MODE_HIGH_RATE;
						missing_tooth_count <= 2'h0;
						last_tooth <= 1'b0;
						insert_tooth_bit <= 1'b0;
						tick_in_tooth <= 10'h000;
					end else if (tooth) begin
						insert_tooth_bit <= 1'b0;
						tick_in_tooth <= 10'h000;
					end else if (tooth_due) begin
						// a missing tooth is consumed; halt only once none remain
						tick_in_tooth <= 10'h000;
						if (missing_tooth_count != 2'h0)
							missing_tooth_count <= missing_tooth_count - 2'h1;
						else
							mode <= `ACL_MODE_HALT;
					end
				end
				`ACL_MODE_HALT: begin
					if (tooth) begin
						angle_time_base <= 24'h000000;
						tb_restart <= 1'b1;
						tick_in_tooth <= 10'h000;
						insert_tooth_bit <= 1'b0;
						if (ticks_pend_valid) begin
							ticks_per_tooth <= ticks_pending;
							ticks_pend_valid <= 1'b0;
						end
						mode <= `ACL_MODE_NORMAL;
					end
				end
				default: mode <= `ACL_MODE_HIGH_RATE;
			endcase
		end
	end
endmodule

// ==== bench/acl_angle_counter_monitor.sv ====
/*
 Port checker for the angle counter.
 Assumes binding to acl_angle_counter, one clock domain.
*/
module acl_angle_counter_monitor (
	input wire clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire tooth_in,
	input wire [1:0] mode,
	input wire [23:0] angle_time_base
);
	timeunit 1ns;
	timeprecision 1ps;
	wire mapped = paddr[1:0] == 2'h0 && paddr <= 12'h010;
	wire rd_setup = psel && !penable && !pwrite;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_ready_high: assert property (psel && penable |-> pready) else $error("ready low");
	a_err_unmapped: assert property (psel && penable && !mapped |-> pslverr) else $error("no err");
	a_no_err_mapped: assert property (psel && penable && mapped |-> !pslverr) else $error("err");
	a_mode_legal: assert property (mode != 2'h3) else $error("bad mode");
	a_status_mode: assert property (rd_setup && paddr == 12'h00C ##1 1 |-> prdata[1:0] == $past(mode))
		else $error("status mode");
	a_read_base: assert property (rd_setup && paddr == 12'h010 |=> prdata[23:0] ==
		$past(angle_time_base)) else $error("time base read");
	a_unmapped_zero: assert property (rd_setup && !mapped |=> prdata == 32'h00000000)
		else $error("unmapped data");
	a_halt_restart: assert property (tooth_in && mode == 2'h2 |=> angle_time_base == 24'h000000)
		else $error("halt restart");
	a_halt_frozen: assert property (mode == 2'h2 ##1 mode == 2'h2 |->
		$stable(angle_time_base)) else $error("halt base moved");
	c_tooth_normal: cover property (tooth_in && mode == 2'h1);
	c_tooth_halt: cover property (tooth_in && mode == 2'h2);
	c_unmapped: cover property (psel && penable && !mapped);
endmodule

// ==== bench/acl_tooth_wheel.sv ====
/*
 Toothed wheel model: one-cycle tooth pulse every gap+1 cycles while on.
 Assumes the bench clock; changes after rising edges only.
*/
module acl_tooth_wheel (
	input wire clk,
	input wire on,
	input wire [7:0] gap,
	output logic tooth
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt = 8'h00;
	initial tooth = 1'b0;
	always @(posedge clk) begin
		cnt <= (on && cnt < gap) ? cnt + 8'h01 : 8'h00;
		tooth <= on && cnt == gap;
	end
endmodule

// ==== bench/test_acl_angle_counter.sv ====
/*
 Self-checking bench for the angle counter.
 Assumes the tooth wheel model and the port checker.
*/
module test_acl_angle_counter;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, on = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, rd, prdata;
	logic err, pready, pslverr, tooth_in;
	logic [1:0] mode;
	logic [23:0] angle_time_base;
	logic [7:0] gap = 8'h07;
	int error_cnt = 0, checks_done = 0;
	// addr, expected data, mask, expected error
	logic [76:0] rows [6] = '{{12'h004, 32'h200, 32'hFFFFFF, 1'b0}, {12'h008, 32'h0, 32'h3F, 1'b0},
		{12'h00C, 32'h0, 32'hF, 1'b0}, {12'h010, 32'h0, 32'hFF000000, 1'b0},
		{12'h014, 32'h0, 32'hFFFFFFFF, 1'b1}, {12'hFFC, 32'h0, 32'hFFFFFFFF, 1'b1}};
	always #10 clk = ~clk;
	acl_angle_counter acl_angle_counter_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tooth_in(tooth_in), .mode(mode), .angle_time_base(angle_time_base));
	acl_tooth_wheel acl_tooth_wheel_i (.clk(clk), .on(on), .gap(gap), .tooth(tooth_in));
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge clk);
		end
		if (n >= 50) begin
			error_cnt++;
			$display("wrong value at %0t: no ready", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		checks_done++;
		if ((got & m) !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got & m, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		error_cnt++;
		finish_test();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		foreach (rows[i]) begin
			apb(0, rows[i][76:65], 32'h0);
			chk(rd, rows[i][64:33], rows[i][32:1]);
			chk({31'h0, err}, {31'h0, rows[i][0]}, 32'h1);
		end
		apb(1, 12'h004, 32'h000800);
		apb(0, 12'h004, 32'h0);
		chk(rd, 32'h000800, 32'hFFFFFF);
		apb(1, 12'h008, 32'h1);
		apb(0, 12'h008, 32'h0);
		chk(rd, 32'h1, 32'h3F);
		apb(1, 12'h020, 32'h5);
		chk({31'h0, err}, 32'h1, 32'h1);
		// dummy teeth walk the mode machine while the wheel is off
		apb(1, 12'h000, 32'h000023FF);
		apb(0, 12'h00C, 32'h0);
		chk(rd, 32'h1, 32'hF);
		apb(1, 12'h000, 32'h00003100);
		apb(0, 12'h00C, 32'h0);
		chk(rd, 32'h6, 32'hF);
		apb(0, 12'h000, 32'h0);
		chk(rd, 32'h3FF, 32'h33FF);
		apb(0, 12'h010, 32'h0);
		chk(rd, 32'h0, 32'hFFFFFF);
		// one real tooth in halt
		gap <= 8'h00;
		@(posedge clk);
		on <= 1;
		@(posedge clk);
		on <= 0;
		apb(0, 12'h000, 32'h0);
		chk(rd, 32'h100, 32'h3FF);
		apb(0, 12'h00C, 32'h0);
		chk(rd, 32'h1, 32'hF);
		apb(0, 12'h010, 32'h0);
		chk(rd, 32'h0, 32'hFFFFF8);
		apb(1, 12'h000, 32'h00000D00);
		apb(1, 12'h000, 32'h00002D00);
		apb(0, 12'h00C, 32'h0);
		chk(rd, 32'h0, 32'h3);
		apb(0, 12'h000, 32'h0);
		chk(rd, 32'h0, 32'h3C00);
		// one missing tooth, one tick per tooth: halt only on the second due tick
		apb(1, 12'h000, 32'h00002401);
		apb(0, 12'h00C, 32'h0);
		chk(rd, 32'h1, 32'h3);
		repeat (40) @(posedge clk);
		apb(0, 12'h00C, 32'h0);
		chk(rd, 32'h2, 32'h3);
		apb(0, 12'h000, 32'h0);
		chk(rd, 32'h0, 32'hC00);
		gap <= 8'h07;
		on <= 1;
		apb(1, 12'h000, 32'h2004);
		repeat (2) @(posedge clk);
		apb(1, 12'h000, 32'h1404);
		repeat (40) begin
			apb(0, 12'h00C, 32'h0);
			apb(0, 12'h010, 32'h0);
			chk({31'h0, err}, 32'h0, 32'h1);
		end
		apb(1, 12'h000, 32'h1004);
		repeat (60) apb(0, 12'h010, 32'h0);
		// reset in mid-run
		on <= 0;
		rst <= 1;
		repeat (2) @(posedge clk);
		chk({30'h0, mode}, 32'h0, 32'h3);
		chk({8'h00, angle_time_base}, 32'h0, 32'hFFFFFF);
		rst <= 0;
		apb(0, 12'h004, 32'h0);
		chk(rd, 32'h200, 32'hFFFFFF);
		apb(0, 12'h00C, 32'h0);
		chk(rd, 32'h0, 32'hF);
		finish_test();
	end
endmodule
bind acl_angle_counter acl_angle_counter_monitor acl_angle_counter_monitor_i (.clk(clk), .rst(rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .tooth_in(tooth_in), .mode(mode),
	.angle_time_base(angle_time_base));
